// file: design/cfs_params.svh
// Constants for the charger fault supervisor: offsets, bits, timing.
// Assumes a 50 MHz core clock; counts derive from it.
`ifndef CFS_PARAMS_SVH
`define CFS_PARAMS_SVH
`define CFS_CLK_KHZ 50000
`define CFS_CNT_W 27
`define CFS_US2CYC(t) (((t) * `CFS_CLK_KHZ) / 1000)
`define CFS_MS2CYC(t) ((t) * `CFS_CLK_KHZ)
`define CFS_ADP_OV_SET_US 10
`define CFS_ADP_OV_CLR_US 100
`define CFS_BOV_DEB_MS 1
`define CFS_OT_CLR_US 100
`define CFS_WOC_SLOT_US 10
`define CFS_WOC_WIN_MS 50
`define CFS_WOC_RST_LONG_MS 1300
`define CFS_WOC_RST_SHORT_MS 150
`define CFS_WOC_LIMIT 3'h7
`define CFS_REG_CTRL2 8'h00
`define CFS_REG_CFG 8'h04
`define CFS_REG_STATUS 8'h08
`define CFS_REG_IRQ_ST 8'h0C
`define CFS_REG_IRQ_MASK 8'h10
`define CFS_C2_BOV_DIS 0
`define CFS_C2_WOC_DIS 1
`define CFS_C2_RST_SEL 11
`define CFS_CTRL2_WMASK 32'h0000_0803
`define CFS_CFG_WMASK 32'h0000_0003
`define CFS_IRQ_WMASK 32'h0000_001F
`define CFS_REG_RST 32'h0000_0000
`define CFS_CELL_ONE 2'h0
`define CFS_CH_ADP 0
`define CFS_CH_BOV 1
`define CFS_CH_SOV 2
`define CFS_CH_OT 3
`define CFS_EV_WOC 4
`endif

// file: design/cfs_pkg.sv
// Types for the charger fault supervisor.
// Used by the design module, the comparator model and the bench; nothing imported.
package cfs_pkg;
   typedef struct packed {
      logic adp_above_ov;
      logic adp_below_rec;
      logic bat_above_max_4p;
      logic bat_above_max_2p;
      logic bat_below_max_2p;
      logic bat_below_max_1p;
      logic sys_above_ov;
      logic sys_below_rec;
      logic in_oc;
      logic bat_oc;
      logic temp_above_140;
      logic temp_below_120;
   } cfs_cmp_t;

   typedef struct packed {
      logic switch_en;
      logic adapter_isolation_gate;
      logic adapter_good_out;
      logic battery_gate;
   } cfs_gate_t;

   typedef enum logic [1:0] {
      CFS_CH_OK = 2'b01,
      CFS_CH_FAULT = 2'b10
   } cfs_chan_st_t;

   typedef enum logic [1:0] {
      CFS_WOC_RUN = 2'b01,
      CFS_WOC_OFF = 2'b10
   } cfs_woc_st_t;
endpackage

// file: design/cfs_fault_supervisor.sv
// Fault supervisor of a buck-boost charger, with Avalon-MM registers.
// Assumes comparator flags synchronous to i_core_clk.
`timescale 1ns/1ps
`include "cfs_params.svh"

// Contract
// - Adapter OV after over 10us above
// - Adapter OV: gate off, good low, battery on
// - Adapter OV clears after over 100us below
// - Battery OV after 1ms above limit stops switching
// - Margin 4% one cell, 2% otherwise
// - Battery OV clears after 1ms below half margin
// - Control bit 0 disables battery OV
// - System OV at 800mV over stops switching
// - System OV clears at once, 300mV below
// - Input 12A or battery 20A trips overcurrent
// - At most one count per 10us
// - Seven counts in 50ms shut down at once
// - Restart after 1.3s or 150ms, bit 11
// - Control bit 1 disables overcurrent function
// - Stop switching above 140 degrees
// - Restart below 120 degrees plus 100us
module cfs_fault_supervisor #(
   parameter logic [`CFS_CNT_W-1:0] P_ADP_CLR_CYC =
      `CFS_CNT_W'(`CFS_US2CYC(`CFS_ADP_OV_CLR_US) + 1),
   parameter logic [`CFS_CNT_W-1:0] P_BOV_DEB_CYC = `CFS_CNT_W'(`CFS_MS2CYC(`CFS_BOV_DEB_MS)),
   parameter logic [`CFS_CNT_W-1:0] P_OT_CLR_CYC = `CFS_CNT_W'(`CFS_US2CYC(`CFS_OT_CLR_US)),
   parameter logic [`CFS_CNT_W-1:0] P_WOC_WIN_CYC = `CFS_CNT_W'(`CFS_MS2CYC(`CFS_WOC_WIN_MS)),
   parameter logic [`CFS_CNT_W-1:0] P_WOC_RST_LONG_CYC =
      `CFS_CNT_W'(`CFS_MS2CYC(`CFS_WOC_RST_LONG_MS)),
   parameter logic [`CFS_CNT_W-1:0] P_WOC_RST_SHORT_CYC =
      `CFS_CNT_W'(`CFS_MS2CYC(`CFS_WOC_RST_SHORT_MS))
)
(
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_clk_en,
   input wire cfs_pkg::cfs_cmp_t i_cmp,
   input wire logic i_battery_gate_req,
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output cfs_pkg::cfs_gate_t o_gates,
   output logic o_irq,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest
);
   localparam logic [`CFS_CNT_W-1:0] ADP_SET_CYC =
      `CFS_CNT_W'(`CFS_US2CYC(`CFS_ADP_OV_SET_US) + 1);
   localparam logic [`CFS_CNT_W-1:0] ONE_CYC = `CFS_CNT_W'(1);
   localparam logic [`CFS_CNT_W-1:0] SLOT_CYC = `CFS_CNT_W'(`CFS_US2CYC(`CFS_WOC_SLOT_US));

   logic [31:0] ctrl2;
   logic [31:0] cfg;
   logic [31:0] irq_st;
   logic [31:0] irq_mask;
   logic [31:0] be_mask;
   logic wr_ack;
   logic bov_en;
   logic woc_en;
   logic one_cell;
   logic [3:0] set_c;
   logic [3:0] clr_c;
   logic [3:0] chan_en;
   logic [3:0] fault;
   logic [3:0] fault_q;
   logic woc_off;
   logic woc_off_q;
   logic [4:0] ev;
   logic [`CFS_CNT_W-1:0] set_cyc [4];
   logic [`CFS_CNT_W-1:0] clr_cyc [4];
   logic [`CFS_CNT_W-1:0] chan_cnt [4];
   cfs_pkg::cfs_chan_st_t chan_st [4];
   cfs_pkg::cfs_woc_st_t woc_st;
   logic [2:0] woc_cnt;
   logic [`CFS_CNT_W-1:0] slot_cnt;
   logic slot_used;
   logic win_active;
   logic [`CFS_CNT_W-1:0] win_cnt;
   logic [`CFS_CNT_W-1:0] rst_cnt;
   logic [`CFS_CNT_W-1:0] rst_cyc;
   logic woc_trip;
   logic win_end;
   cfs_pkg::cfs_gate_t next_gates;

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_reset_n);

   assign be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                     {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
   assign wr_ack = i_clk_en && i_avs_write && !o_avs_waitrequest;
   assign bov_en = !ctrl2[`CFS_C2_BOV_DIS];
   assign woc_en = !ctrl2[`CFS_C2_WOC_DIS];
   assign one_cell = cfg[1:0] == `CFS_CELL_ONE;

   // Comparator choice per fault channel
   always_comb
   begin
      set_c[`CFS_CH_ADP] = i_cmp.adp_above_ov;
      clr_c[`CFS_CH_ADP] = i_cmp.adp_below_rec;
      set_c[`CFS_CH_BOV] = one_cell ? i_cmp.bat_above_max_4p : i_cmp.bat_above_max_2p;
      clr_c[`CFS_CH_BOV] = one_cell ? i_cmp.bat_below_max_2p : i_cmp.bat_below_max_1p;
      set_c[`CFS_CH_SOV] = i_cmp.sys_above_ov;
      clr_c[`CFS_CH_SOV] = i_cmp.sys_below_rec;
      set_c[`CFS_CH_OT] = i_cmp.temp_above_140;
      clr_c[`CFS_CH_OT] = i_cmp.temp_below_120;
      chan_en = 4'h0 | {3'h7, 1'b1};
      chan_en[`CFS_CH_BOV] = bov_en;
      set_cyc[`CFS_CH_ADP] = ADP_SET_CYC;
      clr_cyc[`CFS_CH_ADP] = P_ADP_CLR_CYC;
      set_cyc[`CFS_CH_BOV] = P_BOV_DEB_CYC;
      clr_cyc[`CFS_CH_BOV] = P_BOV_DEB_CYC;
      set_cyc[`CFS_CH_SOV] = ONE_CYC;
      clr_cyc[`CFS_CH_SOV] = ONE_CYC;
      set_cyc[`CFS_CH_OT] = ONE_CYC;
      clr_cyc[`CFS_CH_OT] = P_OT_CLR_CYC;
   end

   // Each channel keeps its own state; a flicker restarts the debounce
   for (genvar g = 0; g < 4; g++)
   begin : g_chan
      always_ff @(posedge i_core_clk or negedge i_reset_n)
      begin
         if (!i_reset_n)
         begin
            chan_st[g] <= cfs_pkg::CFS_CH_OK;
            chan_cnt[g] <= '0;
         end
         else if (i_clk_en)
         begin
            case (chan_st[g])
               cfs_pkg::CFS_CH_OK:
               begin
                  if (chan_en[g] && set_c[g])
                  begin
                     if (chan_cnt[g] >= set_cyc[g] - ONE_CYC)
                     begin
                        chan_st[g] <= cfs_pkg::CFS_CH_FAULT;
                        chan_cnt[g] <= '0;
                     end
                     else
                        chan_cnt[g] <= chan_cnt[g] + ONE_CYC;
                  end
                  else
                     chan_cnt[g] <= '0;
               end
               cfs_pkg::CFS_CH_FAULT:
               begin
                  if (!chan_en[g])
                  begin
                     chan_st[g] <= cfs_pkg::CFS_CH_OK;
                     chan_cnt[g] <= '0;
                  end
                  else if (clr_c[g])
                  begin
                     if (chan_cnt[g] >= clr_cyc[g] - ONE_CYC)
                     begin
                        chan_st[g] <= cfs_pkg::CFS_CH_OK;
                        chan_cnt[g] <= '0;
                     end
                     else
                        chan_cnt[g] <= chan_cnt[g] + ONE_CYC;
                  end
                  else
                     chan_cnt[g] <= '0;
               end
               default:
                  chan_st[g] <= cfs_pkg::CFS_CH_OK;
            endcase
         end
      end
      assign fault[g] = chan_st[g] == cfs_pkg::CFS_CH_FAULT;
   end

   assign woc_trip = woc_en && (i_cmp.in_oc || i_cmp.bat_oc);
   assign rst_cyc = ctrl2[`CFS_C2_RST_SEL] ? P_WOC_RST_SHORT_CYC : P_WOC_RST_LONG_CYC;
   assign woc_off = woc_st == cfs_pkg::CFS_WOC_OFF;
   assign win_end = win_active && (win_cnt >= P_WOC_WIN_CYC - ONE_CYC);

   // Overcurrent slot counting, window and restart wait
   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         woc_st <= cfs_pkg::CFS_WOC_RUN;
         woc_cnt <= 3'h0;
         slot_cnt <= '0;
         slot_used <= 1'b0;
         win_active <= 1'b0;
         win_cnt <= '0;
         rst_cnt <= '0;
      end
      else if (i_clk_en)
      begin
         if (!woc_en)
         begin
            woc_st <= cfs_pkg::CFS_WOC_RUN;
            woc_cnt <= 3'h0;
            slot_used <= 1'b0;
            win_active <= 1'b0;
            win_cnt <= '0;
            rst_cnt <= '0;
         end
         else
         begin
            case (woc_st)
               cfs_pkg::CFS_WOC_RUN:
               begin
                  if (slot_cnt >= SLOT_CYC - ONE_CYC)
                  begin
                     slot_cnt <= '0;
                     slot_used <= 1'b0;
                  end
                  else
                     slot_cnt <= slot_cnt + ONE_CYC;
                  if (win_active)
                  begin
                     if (win_cnt >= P_WOC_WIN_CYC - ONE_CYC)
                     begin
                        win_active <= 1'b0;
                        win_cnt <= '0;
                        woc_cnt <= 3'h0;
                     end
                     else
                        win_cnt <= win_cnt + ONE_CYC;
                  end
                  // Late slot hit may block one count next slot; never over-counts
                  if (woc_trip && !slot_used)
                  begin
                     slot_used <= 1'b1;
                     // Count on the expiry edge opens a fresh window, not a stale one
                     if (win_end)
                     begin
                        woc_cnt <= 3'h1;
                        win_active <= 1'b1;
                        win_cnt <= '0;
                     end
                     else if (woc_cnt == `CFS_WOC_LIMIT - 3'h1)
                     begin
                        woc_st <= cfs_pkg::CFS_WOC_OFF;
                        woc_cnt <= 3'h0;
                        win_active <= 1'b0;
                        win_cnt <= '0;
                        rst_cnt <= '0;
                     end
                     else
                     begin
                        woc_cnt <= woc_cnt + 3'h1;
                        if (!win_active)
                        begin
                           win_active <= 1'b1;
                           win_cnt <= '0;
                        end
                     end
                  end
               end
               cfs_pkg::CFS_WOC_OFF:
               begin
                  if (rst_cnt >= rst_cyc - ONE_CYC)
                  begin
                     woc_st <= cfs_pkg::CFS_WOC_RUN;
                     rst_cnt <= '0;
                     slot_used <= 1'b0;
                  end
                  else
                     rst_cnt <= rst_cnt + ONE_CYC;
               end
               default:
                  woc_st <= cfs_pkg::CFS_WOC_RUN;
            endcase
         end
      end
   end

   always_comb
   begin
      next_gates.switch_en = !(|fault) && !woc_off;
      next_gates.adapter_isolation_gate = !fault[`CFS_CH_ADP] && !woc_off;
      next_gates.adapter_good_out = !fault[`CFS_CH_ADP] && !woc_off;
      next_gates.battery_gate = fault[`CFS_CH_ADP] || i_battery_gate_req;
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_gates <= '0;
      else if (i_clk_en)
         o_gates <= next_gates;
   end

   // Interrupts: fault entry events, set wins over write-one-clear
   assign ev = {woc_off & ~woc_off_q, fault & ~fault_q};

   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         fault_q <= 4'h0;
         woc_off_q <= 1'b0;
         irq_st <= `CFS_REG_RST;
         o_irq <= 1'b0;
      end
      else if (i_clk_en)
      begin
         fault_q <= fault;
         woc_off_q <= woc_off;
         if (wr_ack && i_avs_address == `CFS_REG_IRQ_ST)
            irq_st <= (irq_st & ~(i_avs_writedata & be_mask)) | {27'h000_0000, ev};
         else
            irq_st <= irq_st | {27'h000_0000, ev};
         o_irq <= |(irq_st & irq_mask);
      end
   end

   // Writable registers, taken at the edge that sees waitrequest low
   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         ctrl2 <= `CFS_REG_RST;
         cfg <= `CFS_REG_RST;
         irq_mask <= `CFS_REG_RST;
      end
      else if (wr_ack)
      begin
         if (i_avs_address == `CFS_REG_CTRL2)
            ctrl2 <= (ctrl2 & ~be_mask) | (i_avs_writedata & be_mask & `CFS_CTRL2_WMASK);
         else if (i_avs_address == `CFS_REG_CFG)
            cfg <= (cfg & ~be_mask) | (i_avs_writedata & be_mask & `CFS_CFG_WMASK);
         else if (i_avs_address == `CFS_REG_IRQ_MASK)
            irq_mask <= (irq_mask & ~be_mask) | (i_avs_writedata & be_mask & `CFS_IRQ_WMASK);
      end
   end

   // One wait cycle per access; read data latched while waiting
   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata <= 32'h0000_0000;
      end
      else if (i_clk_en)
      begin
         if (!o_avs_waitrequest)
            o_avs_waitrequest <= 1'b1;
         else if (i_avs_read || i_avs_write)
         begin
            o_avs_waitrequest <= 1'b0;
            if (!i_avs_read)
               o_avs_readdata <= 32'h0000_0000;
            else if (i_avs_address == `CFS_REG_CTRL2)
               o_avs_readdata <= ctrl2;
            else if (i_avs_address == `CFS_REG_CFG)
               o_avs_readdata <= cfg;
            else if (i_avs_address == `CFS_REG_STATUS)
               o_avs_readdata <= {21'h00_0000, woc_cnt, 3'h0, woc_off, fault};
            else if (i_avs_address == `CFS_REG_IRQ_ST)
               o_avs_readdata <= irq_st;
            else if (i_avs_address == `CFS_REG_IRQ_MASK)
               o_avs_readdata <= irq_mask;
            else
               o_avs_readdata <= 32'h0000_0000;
         end
      end
   end

   a_switch_gated: assert property ((i_clk_en && (|fault || woc_off)) |=> !o_gates.switch_en)
      else $error("switching enabled during a fault");
   a_adp_outputs: assert property ((i_clk_en && fault[`CFS_CH_ADP]) |=>
      (!o_gates.adapter_isolation_gate && !o_gates.adapter_good_out && o_gates.battery_gate))
      else $error("adapter fault outputs wrong");
   a_adp_set_time: assert property ($rose(fault[`CFS_CH_ADP]) |->
      $past(chan_cnt[`CFS_CH_ADP]) == ADP_SET_CYC - ONE_CYC)
      else $error("adapter fault declared at wrong time");
   a_bov_disabled: assert property ((i_clk_en && !bov_en) |=> !fault[`CFS_CH_BOV])
      else $error("battery fault while disabled");
   a_woc_disabled: assert property ((i_clk_en && !woc_en) |=> (!woc_off && woc_cnt == 3'h0))
      else $error("overcurrent active while disabled");
   a_woc_trip_count: assert property ($rose(woc_off) |->
      ($past(woc_cnt) == `CFS_WOC_LIMIT - 3'h1 && $past(woc_trip)))
      else $error("overcurrent shutdown without seventh count");
   a_woc_one_per_slot: assert property ((woc_cnt != $past(woc_cnt) && woc_cnt != 3'h0) |->
      $past(!slot_used))
      else $error("two counts in one slot");
   a_sov_release: assert property ((i_clk_en && fault[`CFS_CH_SOV] && clr_c[`CFS_CH_SOV])
      |=> !fault[`CFS_CH_SOV])
      else $error("system fault release delayed");
   a_irq_level: assert property (i_clk_en |=> o_irq == $past(|(irq_st & irq_mask)))
      else $error("interrupt output mismatch");
endmodule

// file: sim/cfs_cmp_model.sv
// Comparator model: analog levels in mV, mA and degrees C turned into flags.
// Assumes the bench changes levels just after a rising clock edge.
`timescale 1ns/1ps
module cfs_cmp_model (
   input int i_adp,
   input int i_bat,
   input int i_sys,
   input int i_max,
   input int i_iin,
   input int i_ibat,
   input int i_temp,
   output cfs_pkg::cfs_cmp_t o_cmp
);
   // Gap between set and clear levels, so a middle level sets neither flag
   always_comb
   begin
      o_cmp.adp_above_ov = i_adp > 23400;
      o_cmp.adp_below_rec = i_adp < 23040;
      o_cmp.bat_above_max_4p = i_bat * 100 > i_max * 104;
      o_cmp.bat_above_max_2p = i_bat * 100 > i_max * 102;
      o_cmp.bat_below_max_2p = i_bat * 100 <= i_max * 102;
      o_cmp.bat_below_max_1p = i_bat * 100 <= i_max * 101;
      o_cmp.sys_above_ov = i_sys > i_max + 800;
      o_cmp.sys_below_rec = i_sys < i_max + 500;
      o_cmp.in_oc = i_iin > 12000;
      o_cmp.bat_oc = i_ibat > 20000;
      o_cmp.temp_above_140 = i_temp > 140;
      o_cmp.temp_below_120 = i_temp < 120;
   end
endmodule

// file: sim/testbench.sv
// Bench for the charger fault supervisor: bus tasks and fault sequences.
// Assumes one wait cycle per access and shortened debounce parameters.
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic bgreq = 1'b0;
   logic ce = 1'b1;
   logic [3:0] be = 4'hF;
   logic [7:0] addr = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata;
   logic [31:0] q;
   logic wreq;
   logic irq;
   int adapter_sense = 20000, bat = 10000, sys = 10000, mx = 10000, iin = 0, ibat = 0, temp = 25;
   int err_count = 0;
   int n_compared = 0;
   cfs_pkg::cfs_cmp_t cmp;
   cfs_pkg::cfs_gate_t gates;

   always #10 clk = ~clk;

   cfs_cmp_model cmp_u (.i_adp(adapter_sense), .i_bat(bat), .i_sys(sys), .i_max(mx), .i_iin(iin),
      .i_ibat(ibat), .i_temp(temp), .o_cmp(cmp));

   // Short counts keep the run brief; over-temperature release keeps its full count
   cfs_fault_supervisor #(.P_ADP_CLR_CYC(27'h00_0014), .P_BOV_DEB_CYC(27'h00_001E),
      .P_WOC_WIN_CYC(27'h00_4E20),
      .P_WOC_RST_LONG_CYC(27'h00_012C), .P_WOC_RST_SHORT_CYC(27'h00_0064)) dut_u (
      .i_core_clk(clk), .i_reset_n(rst_n), .i_clk_en(ce), .i_cmp(cmp),
      .i_battery_gate_req(bgreq), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_gates(gates), .o_irq(irq),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wreq));

   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e)
      begin
         err_count++;
         $display("ERROR %0t ns: seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic gchk(input logic [3:0] e);
      chk(32'(gates), 32'(e));
   endtask

   // Request held until waitrequest is seen low; one idle edge follows
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      addr <= a;
      wr <= w;
      rd <= ~w;
      wdata <= d;
      do
      begin
         @(posedge clk);
         t++;
      end
      while (wreq !== 1'b0 && t < 40);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      if (t >= 40)
         chk(32'h0000_0000, 32'h0000_0001);
      @(posedge clk);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(q, e);
   endtask

   // Bounded wait for the switch enable to reach a level
   task automatic wsw(input logic v, input int n);
      int t;
      t = 0;
      while (gates.switch_en !== v && t < n)
      begin
         @(posedge clk);
         t++;
      end
      chk(32'(gates.switch_en), 32'(v));
   endtask

   initial
   begin
      cyc(16);
      gchk(4'h0);
      chk(32'(wreq), 32'h0000_0001);
      rst_n <= 1'b1;
      cyc(3);
      gchk(4'hE);
      for (int i = 0; i < 6; i++)
         rchk(8'(4 * i), 32'h0000_0000);
      be <= 4'hE;
      bus(1'b1, 8'h10, 32'h0000_001F);
      be <= 4'hF;
      rchk(8'h10, 32'h0000_0000);
      bgreq <= 1'b1;
      cyc(3);
      gchk(4'hF);
      bgreq <= 1'b0;
      cyc(3);
      $display("reset test done");
      adapter_sense <= 24000;
      cyc(400);
      adapter_sense <= 23200;
      cyc(1);
      adapter_sense <= 24000;
      cyc(490);
      gchk(4'hE);
      cyc(20);
      gchk(4'h1);
      rchk(8'h08, 32'h0000_0001);
      adapter_sense <= 23000;
      cyc(12);
      gchk(4'h1);
      cyc(15);
      gchk(4'hE);
      bus(1'b1, 8'h0C, 32'h0000_001F);
      $display("adapter test done");
      bus(1'b1, 8'h10, 32'h0000_0004);
      ce <= 1'b0;
      sys <= 10900;
      cyc(4);
      gchk(4'hE);
      ce <= 1'b1;
      cyc(4);
      gchk(4'h6);
      chk(32'(irq), 32'h0000_0001);
      sys <= 10600;
      cyc(10);
      gchk(4'h6);
      sys <= 10400;
      cyc(3);
      gchk(4'hE);
      sys <= 10900;
      temp <= 150;
      cyc(4);
      sys <= 10400;
      cyc(4);
      gchk(4'h6);
      rchk(8'h08, 32'h0000_0008);
      temp <= 130;
      cyc(40);
      gchk(4'h6);
      temp <= 100;
      cyc(4990);
      gchk(4'h6);
      cyc(20);
      gchk(4'hE);
      bus(1'b1, 8'h0C, 32'h0000_0004);
      cyc(2);
      chk(32'(irq), 32'h0000_0000);
      bus(1'b1, 8'h0C, 32'h0000_001F);
      $display("system and temperature test done");
      bus(1'b1, 8'h04, 32'h0000_0001);
      bat <= 10300;
      cyc(20);
      gchk(4'hE);
      cyc(20);
      gchk(4'h6);
      bat <= 10150;
      cyc(40);
      gchk(4'h6);
      bat <= 10050;
      cyc(40);
      gchk(4'hE);
      bus(1'b1, 8'h04, 32'h0000_0000);
      bat <= 10300;
      cyc(40);
      gchk(4'hE);
      bat <= 10500;
      cyc(40);
      gchk(4'h6);
      bus(1'b1, 8'h00, 32'h0000_0001);
      cyc(3);
      gchk(4'hE);
      bat <= 10000;
      bus(1'b1, 8'h00, 32'h0000_0000);
      $display("battery test done");
      iin <= 15000;
      cyc(2400);
      gchk(4'hE);
      wsw(1'b0, 2000);
      chk(32'(gates[3:1]), 32'h0000_0000);
      rchk(8'h08, 32'h0000_0010);
      iin <= 0;
      cyc(250);
      chk(32'(gates.switch_en), 32'h0000_0000);
      wsw(1'b1, 100);
      bus(1'b1, 8'h00, 32'h0000_0800);
      ibat <= 25000;
      wsw(1'b0, 4500);
      ibat <= 0;
      cyc(80);
      chk(32'(gates.switch_en), 32'h0000_0000);
      wsw(1'b1, 60);
      iin <= 15000;
      cyc(1600);
      iin <= 0;
      cyc(21000);
      iin <= 15000;
      cyc(2400);
      gchk(4'hE);
      iin <= 0;
      cyc(21000);
      bus(1'b1, 8'h00, 32'h0000_0002);
      iin <= 15000;
      cyc(4000);
      gchk(4'hE);
      iin <= 0;
      $display("overcurrent test done");
      complete_run();
   end

   // Well past the expected run length, still under the cycle budget
   initial
   begin
      cyc(90000);
      err_count++;
      complete_run();
   end
endmodule
